// ---- hdl/txs_shaper_cfg.sv ----
// Implementation choice: strobed register access.
`timescale 1ns/1ps
`include "txs_params.svh"
module txs_shaper_cfg
	import txs_pkg::*;
(
	input wire logic CLK_IN,
	input wire logic RST_N_IN,
	input wire logic [15:0] ADDR_IN,
	input wire logic [7:0] WDATA_IN,
	input wire logic WR_IN,
	input wire logic RD_IN,
	output logic [7:0] RDATA_OUT,
	input wire logic CARRIER_IN,
	input wire logic MOD_IN,
	output logic [7:0] AMPL_OUT,
	output logic EDGE_ACTIVE_OUT,
	output logic EDGE_RISING_OUT,
	output logic [4:0] EDGE_STATE_OUT,
	output logic [1:0] SEGMENTS_OUT,
	output logic USE_LUT_OUT,
	output logic [1:0] LUT_SEL_OUT,
	output logic [2:0] TIME_CONST_OUT,
	output logic SUPPLY_ADAPT_OUT,
	output logic CORRECTION_OUT,
	output logic STYLE_INVALID_OUT
);

	// ---------------------------------------------------------------
	// reset release
	// ---------------------------------------------------------------
	logic rst_meta_n;
	logic rst_n;

	// two-flop release of the asynchronous reset
	always_ff @(posedge CLK_IN or negedge RST_N_IN)
	begin
		if (!RST_N_IN)
		begin
			rst_meta_n <= 1'b0;
			rst_n <= 1'b0;
		end
		else
		begin
			rst_meta_n <= 1'b1;
			rst_n <= rst_meta_n;
		end
	end

	// ---------------------------------------------------------------
	// pin synchronisers
	// ---------------------------------------------------------------
	logic car_meta;
	logic car_sync;
	logic car_prev;
	logic mod_meta;
	logic mod_sync;
	logic carrier_tick;

	// carrier and modulation pins pass two flops first
	always_ff @(posedge CLK_IN or negedge rst_n)
	begin
		if (!rst_n)
		begin
			car_meta <= 1'b0;
			car_sync <= 1'b0;
			car_prev <= 1'b0;
			mod_meta <= 1'b0;
			mod_sync <= 1'b0;
		end
		else
		begin
			car_meta <= CARRIER_IN;
			car_sync <= car_meta;
			car_prev <= car_sync;
			mod_meta <= MOD_IN;
			mod_sync <= mod_meta;
		end
	end

	assign carrier_tick = car_sync & ~car_prev; // one carrier cycle

	// ---------------------------------------------------------------
	// register file
	// ---------------------------------------------------------------
	logic [7:0] kind_typea;
	logic [7:0] style_typea;
	logic [7:0] len_typea;
	logic [7:0] resid_typeb;
	logic [7:0] kind_typeb;
	logic [7:0] ctrl;
	logic [7:0] status;
	logic [7:0] next_rdata;

	// software writes; reserved bits are masked away
	always_ff @(posedge CLK_IN or negedge rst_n)
	begin
		if (!rst_n)
		begin
			kind_typea <= `TXS_RST_KIND;
			style_typea <= `TXS_RST_STYLE;
			len_typea <= `TXS_RST_LEN;
			resid_typeb <= `TXS_RST_RESID;
			kind_typeb <= `TXS_RST_KIND;
			ctrl <= `TXS_RST_CTRL;
		end
		else if (WR_IN)
		begin
			unique case (ADDR_IN)
				`TXS_OFS_KIND_TYPEA: kind_typea <= WDATA_IN;
				`TXS_OFS_STYLE_TYPEA: style_typea <= WDATA_IN & `TXS_MASK_STYLE;
				`TXS_OFS_LEN_TYPEA: len_typea <= WDATA_IN & `TXS_MASK_LEN;
				`TXS_OFS_RESID_TYPEB: resid_typeb <= WDATA_IN & `TXS_MASK_FULL;
				`TXS_OFS_KIND_TYPEB: kind_typeb <= WDATA_IN;
				`TXS_OFS_CTRL: ctrl <= WDATA_IN & `TXS_MASK_CTRL;
				default: ;
			endcase
		end
	end

	// read mux; unmapped addresses read zero
	always_comb
	begin
		next_rdata = 8'h00;
		unique case (ADDR_IN)
			`TXS_OFS_KIND_TYPEA: next_rdata = kind_typea;
			`TXS_OFS_STYLE_TYPEA: next_rdata = style_typea;
			`TXS_OFS_LEN_TYPEA: next_rdata = len_typea;
			`TXS_OFS_RESID_TYPEB: next_rdata = resid_typeb;
			`TXS_OFS_KIND_TYPEB: next_rdata = kind_typeb;
			`TXS_OFS_CTRL: next_rdata = ctrl;
			`TXS_OFS_STATUS: next_rdata = status;
			default: next_rdata = 8'h00;
		endcase
	end

	// read data stands in the cycle after the strobe only
	always_ff @(posedge CLK_IN or negedge rst_n)
	begin
		if (!rst_n)
			RDATA_OUT <= 8'h00;
		else if (RD_IN)
			RDATA_OUT <= next_rdata;
		else
			RDATA_OUT <= 8'h00;
	end

	// ---------------------------------------------------------------
	// active setting selection
	// ---------------------------------------------------------------
	logic typeb;
	logic [7:0] kind_reg;
	logic [3:0] kind_code;
	logic [2:0] style_field;
	logic [4:0] state_count;
	logic dbl;
	logic [7:0] low_level;
	logic rising;

	assign typeb = ctrl[`TXS_CTRL_TYPEB_BIT];
	assign kind_reg = typeb ? kind_typeb : kind_typea;
	assign dbl = len_typea[`TXS_LEN_DBL_BIT];
	assign state_count = len_typea[`TXS_LEN_CNT_HI:0];
	assign low_level = typeb ? resid_typeb : `TXS_AMPL_TYPEA;

	// edge direction picks the style nibble and style field
	always_comb
	begin
		if (rising)
		begin
			kind_code = kind_reg[`TXS_RISE_HI:`TXS_RISE_LO];
			style_field = style_typea[`TXS_STY_RISE_HI:0];
		end
		else
		begin
			kind_code = kind_reg[`TXS_FALL_HI:`TXS_FALL_LO];
			style_field = style_typea[`TXS_STY_FALL_HI:`TXS_FALL_LO];
		end
	end

	// ---------------------------------------------------------------
	// edge sequencer
	// ---------------------------------------------------------------
	txs_state_t state;
	txs_state_t next_state;
	logic [4:0] step;
	logic half;
	logic state_done;

	assign rising = (state == TXS_RISE);
	// a state lasts one carrier cycle, or two when doubled
	assign state_done = carrier_tick & (~dbl | half);

	// state transitions
	always_comb
	begin
		next_state = state;
		unique case (state)
			TXS_IDLE:
				if (mod_sync)
					next_state = (state_count == 5'h00) ? TXS_LOW : TXS_FALL;
			TXS_FALL:
				if (state_done && step == state_count - 5'h01)
					next_state = TXS_LOW;
			TXS_LOW:
				if (!mod_sync)
					next_state = (state_count == 5'h00) ? TXS_IDLE : TXS_RISE;
			TXS_RISE:
				if (state_done && step == state_count - 5'h01)
					next_state = TXS_IDLE;
		endcase
	end

	// state register
	always_ff @(posedge CLK_IN or negedge rst_n)
	begin
		if (!rst_n)
			state <= TXS_IDLE;
		else
			state <= next_state;
	end

	// transition state counter and carrier half counter
	always_ff @(posedge CLK_IN or negedge rst_n)
	begin
		if (!rst_n)
		begin
			step <= 5'h00;
			half <= 1'b0;
		end
		else if (next_state != state)
		begin
			step <= 5'h00;
			half <= 1'b0;
		end
		else if (state == TXS_FALL || state == TXS_RISE)
		begin
			if (carrier_tick)
				half <= ~half & dbl;
			if (state_done)
				step <= step + 5'h01;
		end
	end

	// ---------------------------------------------------------------
	// shaper control outputs
	// ---------------------------------------------------------------
	logic is_edge;

	assign is_edge = (state == TXS_FALL) || (state == TXS_RISE);

	// style decode towards the wave shaper
	always_ff @(posedge CLK_IN or negedge rst_n)
	begin
		if (!rst_n)
		begin
			SEGMENTS_OUT <= 2'b00;
			USE_LUT_OUT <= 1'b0;
			LUT_SEL_OUT <= 2'b00;
			TIME_CONST_OUT <= 3'b000;
			SUPPLY_ADAPT_OUT <= 1'b0;
			CORRECTION_OUT <= 1'b0;
			STYLE_INVALID_OUT <= 1'b0;
		end
		else
		begin
			SEGMENTS_OUT <= 2'b00;
			USE_LUT_OUT <= 1'b0;
			LUT_SEL_OUT <= 2'b00;
			TIME_CONST_OUT <= 3'b000;
			SUPPLY_ADAPT_OUT <= 1'b0;
			CORRECTION_OUT <= 1'b0;
			STYLE_INVALID_OUT <= 1'b0;
			unique case (kind_code)
				TXS_LIN1, TXS_LIN2, TXS_LIN3:
				begin
					SEGMENTS_OUT <= kind_code[1:0];
					TIME_CONST_OUT <= style_field;
				end
				TXS_LUT_FIX:
				begin
					USE_LUT_OUT <= 1'b1;
					LUT_SEL_OUT <= style_field[1:0];
				end
				TXS_LUT_ADAPT_CORR:
				begin
					USE_LUT_OUT <= 1'b1;
					LUT_SEL_OUT <= style_field[1:0];
					SUPPLY_ADAPT_OUT <= 1'b1;
					CORRECTION_OUT <= 1'b1;
				end
				TXS_LUT_ADAPT:
				begin
					USE_LUT_OUT <= 1'b1;
					LUT_SEL_OUT <= style_field[1:0];
					SUPPLY_ADAPT_OUT <= 1'b1;
				end
				default: STYLE_INVALID_OUT <= 1'b1; // reserved code
			endcase
		end
	end

	// edge progress and steady carrier level
	always_ff @(posedge CLK_IN or negedge rst_n)
	begin
		if (!rst_n)
		begin
			AMPL_OUT <= `TXS_AMPL_FULL;
			EDGE_ACTIVE_OUT <= 1'b0;
			EDGE_RISING_OUT <= 1'b0;
			EDGE_STATE_OUT <= 5'h00;
		end
		else
		begin
			EDGE_ACTIVE_OUT <= is_edge;
			EDGE_RISING_OUT <= rising;
			EDGE_STATE_OUT <= is_edge ? step : 5'h00;
			if (state == TXS_LOW)
				AMPL_OUT <= low_level;
			else
				AMPL_OUT <= `TXS_AMPL_FULL;
		end
	end

	// status: type B flag, invalid style, direction, state
	assign status = {3'b000, typeb, STYLE_INVALID_OUT, rising, state};

endmodule // txs_shaper_cfg

// ---- hdl/txs_params.svh ----
// Functional notes
// - firmware shaping (codes 1-3): style bits 6:4 pick falling-edge time constant.
// - table shaping (codes 4-6): falling style field picks lookup table 0 to 3.
// - style bits 2:0 give rising time constant or rising table index.
// - table shaping: rising style field picks one of four lookup tables.
// - length bit 7: one carrier cycle per state when clear, two when set.
// - the doubling acts on rising and falling edges together.
// - length bits 4:0 give active transition states, shared by both edges.
// - type B residual amplitude scales carrier linearly, 0x00 none, 0xFF full.
// - edge type bits 7:4 select the falling-edge transition style.
// - edge type bits 3:0 select rising-edge style, same code set.
// - codes 1, 2, 3 give one, two, three linear firmware-computed segments.
// - code 4 is table based with no supply adaptation.
// - code 5 is table based, supply adapted, with correction step.
// - code 6 is table based, supply adapted, without correction step.
`ifndef TXS_PARAMS_SVH
`define TXS_PARAMS_SVH
// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define TXS_ADDR_W 16
`define TXS_OFS_KIND_TYPEA 16'h0021
`define TXS_OFS_STYLE_TYPEA 16'h0022
`define TXS_OFS_LEN_TYPEA 16'h0023
`define TXS_OFS_RESID_TYPEB 16'h0024
`define TXS_OFS_KIND_TYPEB 16'h0025
`define TXS_OFS_CTRL 16'h0030
`define TXS_OFS_STATUS 16'h0031
// ---------------------------------------------------------------
// writable bit masks and reset values
// ---------------------------------------------------------------
`define TXS_MASK_STYLE 8'h77
`define TXS_MASK_LEN 8'h9F
`define TXS_MASK_FULL 8'hFF
`define TXS_MASK_CTRL 8'h01
`define TXS_RST_KIND 8'h11
`define TXS_RST_STYLE 8'h00
`define TXS_RST_LEN 8'h00
`define TXS_RST_RESID 8'h00
`define TXS_RST_CTRL 8'h00
// ---------------------------------------------------------------
// field positions and levels
// ---------------------------------------------------------------
`define TXS_FALL_HI 7
`define TXS_FALL_LO 4
`define TXS_RISE_HI 3
`define TXS_RISE_LO 0
`define TXS_STY_FALL_HI 6
`define TXS_STY_RISE_HI 2
`define TXS_LEN_DBL_BIT 7
`define TXS_LEN_CNT_HI 4
`define TXS_CTRL_TYPEB_BIT 0
`define TXS_AMPL_FULL 8'hFF
`define TXS_AMPL_TYPEA 8'h00
`endif

// ---- hdl/txs_pkg.sv ----
package txs_pkg;
	// sequencer states
	typedef enum logic [1:0] {
		TXS_IDLE = 2'b00,
		TXS_FALL = 2'b01,
		TXS_LOW = 2'b10,
		TXS_RISE = 2'b11
	} txs_state_t;
	// edge transition style codes
	typedef enum logic [3:0] {
		TXS_LIN1 = 4'h1,
		TXS_LIN2 = 4'h2,
		TXS_LIN3 = 4'h3,
		TXS_LUT_FIX = 4'h4,
		TXS_LUT_ADAPT_CORR = 4'h5,
		TXS_LUT_ADAPT = 4'h6
	} txs_kind_t;
endpackage

// ---- sim/txs_tx_drv.sv ----
`timescale 1ns/1ps
module txs_tx_drv (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic mod_req_in,
	output logic carrier_out,
	output logic mod_out
);
	logic [2:0] div;
	logic req;
	// carrier at one eighth of the clock, modulation request registered
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			div <= 3'h0;
			req <= 1'b0;
		end
		else
		begin
			div <= div + 3'h1;
			req <= mod_req_in;
		end
	end
	// both lines rest low while in reset
	assign carrier_out = rst_n_in & div[2];
	assign mod_out = rst_n_in & req;
endmodule // txs_tx_drv

// ---- sim/txs_shaper_cfg_checker.sv ----
`timescale 1ns/1ps
module txs_shaper_cfg_checker (
	input wire logic CLK_IN,
	input wire logic RST_N_IN,
	input wire logic RD_IN,
	input wire logic [7:0] RDATA_OUT,
	input wire logic [7:0] AMPL_OUT,
	input wire logic EDGE_ACTIVE_OUT,
	input wire logic EDGE_RISING_OUT,
	input wire logic [4:0] EDGE_STATE_OUT,
	input wire logic [1:0] SEGMENTS_OUT,
	input wire logic USE_LUT_OUT,
	input wire logic SUPPLY_ADAPT_OUT,
	input wire logic CORRECTION_OUT,
	input wire logic STYLE_INVALID_OUT
);
	default clocking cb @(posedge CLK_IN);
	endclocking
	default disable iff (!RST_N_IN);
	// read data only in the cycle after a read strobe
	a_rdata_idle: assert property (!$past(RD_IN) |-> RDATA_OUT == 8'h00)
		else $error("read data outside read cycle");
	a_lut_decode: assert property (USE_LUT_OUT |-> SEGMENTS_OUT == 2'h0 && !STYLE_INVALID_OUT)
		else $error("table mode with segments");
	a_corr_adapt: assert property (CORRECTION_OUT |-> SUPPLY_ADAPT_OUT && USE_LUT_OUT)
		else $error("correction without adaptation");
	a_adapt_lut: assert property (SUPPLY_ADAPT_OUT |-> USE_LUT_OUT && SEGMENTS_OUT == 2'h0)
		else $error("adaptation outside table mode");
	a_fw_decode: assert property (SEGMENTS_OUT != 2'h0 |-> !USE_LUT_OUT && !STYLE_INVALID_OUT)
		else $error("segments with table mode");
	a_invalid_decode: assert property (STYLE_INVALID_OUT |-> !USE_LUT_OUT && SEGMENTS_OUT == 2'h0)
		else $error("invalid code decoded");
	a_state_zero: assert property (!EDGE_ACTIVE_OUT |-> EDGE_STATE_OUT == 5'h00)
		else $error("state index outside edge");
	a_state_step: assert property (EDGE_ACTIVE_OUT && $past(EDGE_ACTIVE_OUT)
		&& EDGE_RISING_OUT == $past(EDGE_RISING_OUT) |-> EDGE_STATE_OUT == $past(EDGE_STATE_OUT)
		|| EDGE_STATE_OUT == $past(EDGE_STATE_OUT) + 5'h01)
		else $error("state index jumped");
	a_ampl_edge: assert property (EDGE_ACTIVE_OUT |-> AMPL_OUT == 8'hFF)
		else $error("amplitude reduced during edge");
endmodule // txs_shaper_cfg_checker
bind txs_shaper_cfg txs_shaper_cfg_checker u_chk (.CLK_IN, .RST_N_IN, .RD_IN, .RDATA_OUT,
	.AMPL_OUT, .EDGE_ACTIVE_OUT, .EDGE_RISING_OUT, .EDGE_STATE_OUT, .SEGMENTS_OUT,
	.USE_LUT_OUT, .SUPPLY_ADAPT_OUT, .CORRECTION_OUT, .STYLE_INVALID_OUT);

// ---- sim/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
	logic CLK_IN, RST_N_IN, WR_IN, RD_IN, CARRIER_IN, MOD_IN, mod_req, rdv;
	logic [15:0] ADDR_IN;
	logic [7:0] WDATA_IN, RDATA_OUT, AMPL_OUT, r, s;
	logic EDGE_ACTIVE_OUT, EDGE_RISING_OUT, USE_LUT_OUT, SUPPLY_ADAPT_OUT, CORRECTION_OUT;
	logic STYLE_INVALID_OUT;
	logic [4:0] EDGE_STATE_OUT;
	logic [1:0] SEGMENTS_OUT, LUT_SEL_OUT;
	logic [2:0] TIME_CONST_OUT;
	logic [16:0] lfsr;
	logic [7:0] q[$];
	logic [7:0] wv[6];
	logic [7:0] msk[6] = '{8'hFF, 8'h77, 8'h9F, 8'hFF, 8'hFF, 8'h00};
	int mismatches = 0;
	int n_tests = 0;
	txs_shaper_cfg DUT (.CLK_IN(CLK_IN), .RST_N_IN(RST_N_IN), .ADDR_IN(ADDR_IN),
		.WDATA_IN(WDATA_IN), .WR_IN(WR_IN), .RD_IN(RD_IN), .RDATA_OUT(RDATA_OUT),
		.CARRIER_IN(CARRIER_IN), .MOD_IN(MOD_IN), .AMPL_OUT(AMPL_OUT),
		.EDGE_ACTIVE_OUT(EDGE_ACTIVE_OUT), .EDGE_RISING_OUT(EDGE_RISING_OUT),
		.EDGE_STATE_OUT(EDGE_STATE_OUT), .SEGMENTS_OUT(SEGMENTS_OUT),
		.USE_LUT_OUT(USE_LUT_OUT), .LUT_SEL_OUT(LUT_SEL_OUT),
		.TIME_CONST_OUT(TIME_CONST_OUT), .SUPPLY_ADAPT_OUT(SUPPLY_ADAPT_OUT),
		.CORRECTION_OUT(CORRECTION_OUT), .STYLE_INVALID_OUT(STYLE_INVALID_OUT));
	txs_tx_drv u_drv (.clk_in(CLK_IN), .rst_n_in(RST_N_IN), .mod_req_in(mod_req),
		.carrier_out(CARRIER_IN), .mod_out(MOD_IN));
	// clock
	initial
	begin
		CLK_IN = 1'b0;
		forever #5 CLK_IN = ~CLK_IN;
	end
	function automatic logic [16:0] nxt(input logic [16:0] v);
		return {v[15:0], v[16] ^ v[13]};
	endfunction
	// expected decode pack for a style code and style field
	function automatic logic [7:0] dec(input logic [3:0] c, input logic [2:0] f);
		logic fw, lut;
		fw = c >= 4'h1 && c <= 4'h3;
		lut = c >= 4'h4 && c <= 4'h6;
		return {fw ? c[1:0] : 2'h0, lut, lut ? f[1:0] : 2'h0, c == 4'h5 || c == 4'h6,
			c == 4'h5, !(fw || lut)};
	endfunction
	function automatic logic [7:0] pk();
		return {SEGMENTS_OUT, USE_LUT_OUT, LUT_SEL_OUT & {2{USE_LUT_OUT}}, SUPPLY_ADAPT_OUT,
			CORRECTION_OUT, STYLE_INVALID_OUT};
	endfunction
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			mismatches++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		ADDR_IN <= a;
		WDATA_IN <= d;
		WR_IN <= 1'b1;
		RD_IN <= 1'b0;
		@(posedge CLK_IN);
	endtask
	task automatic rd(input logic [15:0] a, input logic [7:0] e);
		q.push_back(e);
		ADDR_IN <= a;
		RD_IN <= 1'b1;
		WR_IN <= 1'b0;
		@(posedge CLK_IN);
	endtask
	task automatic idle();
		WR_IN <= 1'b0;
		RD_IN <= 1'b0;
		@(posedge CLK_IN);
	endtask
	task automatic tick(inout int n);
		@(negedge CLK_IN);
		n++;
		if (n > 299)
		begin
			mismatches++;
			$display("mismatch at %0t: wait timed out", $time);
			wrap_up();
		end
	endtask
	// one edge: table choice, state duration, state count, settled level
	task automatic edge_run(input logic rise, input int d, input logic [7:0] lvl);
		int n;
		n = 0;
		while (!(EDGE_STATE_OUT === 5'h01 && EDGE_RISING_OUT === rise))
			tick(n);
		chk(pk(), rise ? dec(4'h6, 3'h2) : dec(4'h4, 3'h5));
		n = 0;
		while (EDGE_STATE_OUT === 5'h01)
			tick(n);
		chk(8'(n), 8'(8 * (d + 1)));
		chk({3'h0, EDGE_STATE_OUT}, 8'h02);
		n = 0;
		while (EDGE_ACTIVE_OUT !== 1'b0)
			tick(n);
		chk(8'(n), 8'(8 * (d + 1)));
		repeat (3) @(negedge CLK_IN);
		chk(AMPL_OUT, lvl);
		@(posedge CLK_IN);
	endtask
	// read results checked in the cycle after each read strobe
	always @(posedge CLK_IN)
	begin
		if (rdv === 1'b1)
			chk(RDATA_OUT, q.pop_front());
		rdv <= RD_IN;
	end
	// main sequence
	initial
	begin
		{RST_N_IN, WR_IN, RD_IN, mod_req} = 4'h0;
		ADDR_IN = 16'h0000;
		WDATA_IN = 8'h00;
		lfsr = 17'h118C3;
		repeat (10) @(posedge CLK_IN);
		RST_N_IN <= 1'b1;
		repeat (3) @(posedge CLK_IN);
		for (int i = 0; i < 6; i++)
			rd(16'h0021 + 16'(i), (i == 0 || i == 4) ? 8'h11 : 8'h00);
		for (int i = 0; i < 6; i++)
		begin
			lfsr = nxt(lfsr);
			wv[i] = lfsr[7:0];
			wr(16'h0021 + 16'(i), wv[i]);
		end
		for (int i = 0; i < 6; i++)
			rd(16'h0021 + 16'(i), wv[i] & msk[i]);
		idle();
		$display("test registers done");
		wr(16'h0030, 8'h01);
		for (int k = 0; k < 8; k++)
		begin
			lfsr = nxt(lfsr);
			s = lfsr[7:0] & 8'h77;
			wr(16'h0022, s);
			wr(16'h0025, {4'(k), 4'h1});
			idle();
			repeat (3) @(posedge CLK_IN);
			@(negedge CLK_IN);
			chk(pk(), dec(4'(k), s[6:4]));
			if (k >= 1 && k <= 3)
				chk({5'h00, TIME_CONST_OUT}, {5'h00, s[6:4]});
			@(posedge CLK_IN);
		end
		$display("test style codes done");
		for (int d = 0; d < 2; d++)
		begin
			lfsr = nxt(lfsr);
			r = lfsr[7:0];
			wr(16'h0030, {7'h00, d[0]});
			wr(16'h0024, r);
			wr(16'h0023, {d[0], 7'h03});
			wr(16'h0021, 8'h46);
			wr(16'h0025, 8'h46);
			wr(16'h0022, 8'h52);
			rd(16'h0030, {7'h00, d[0]});
			idle();
			mod_req <= 1'b1;
			edge_run(1'b0, d, (d == 1) ? r : 8'h00);
			mod_req <= 1'b0;
			edge_run(1'b1, d, 8'hFF);
		end
		$display("test edges done");
		wrap_up();
	end
endmodule // tb_top
